// ==== hw/icc_pkg.sv ====
// Package with register map, field layout and timing constants of the inductive converter control block.
// What this block does
// RQ1: After reset the block sleeps, not converting, ready for configuration writes.
// RQ2: Writing 0x01 to mode register 0x0B stops conversions.
// RQ3: Writing 0x00 to mode register starts continuous conversions.
// RQ4: Status register 0x20 bit 6 shows resistance and inductance data ready.
// RQ5: Resistance result low byte at 0x21, high byte at 0x22.
// RQ6: Inductance result low byte at 0x23, high byte at 0x24.
// RQ7: Extended SPI reads advance the address over consecutive result registers.
// RQ8: High-resolution status 0x3B bit 0 shows a fresh high-resolution result.
// RQ9: High-resolution result readable at 0x38, 0x39 and 0x3A.
// RQ10: High-resolution reference count is 16 bits in low and high byte registers.
// RQ11: High-resolution period is 16 reference cycles per count plus 55 cycles.
// RQ12: Both conversion kinds run on independent timers with own ready flags.
// RQ13: Range register 0x01 holds disable bit, max code and min code.
// RQ14: Time constant one register packs two-bit capacitor and five-bit resistor codes.
// RQ15: Digital config 0x04 holds frequency field high nibble, response time low bits.
// RQ16: Frequency field value 14 selects a 4.0 MHz watchdog threshold.
// RQ17: Host keeps maximum-range disable cleared for sensor quality below 50.
// RQ18: Response time 6144 gives the longest conversion, 3072 half as long.
// RQ19: High-resolution bytes are ordered least significant first.
// RQ20: Data-ready bits read zero when fresh and return to one after reading.
`default_nettype none
package icc_pkg;
    // Register offsets.
    localparam logic [6:0] ICC_ADR_RANGE = 7'h01;
    localparam logic [6:0] ICC_ADR_TC1 = 7'h02;
    localparam logic [6:0] ICC_ADR_TC2 = 7'h03;
    localparam logic [6:0] ICC_ADR_DIG = 7'h04;
    localparam logic [6:0] ICC_ADR_MODE = 7'h0B;
    localparam logic [6:0] ICC_ADR_STAT = 7'h20;
    localparam logic [6:0] ICC_ADR_RP_LO = 7'h21;
    localparam logic [6:0] ICC_ADR_RP_HI = 7'h22;
    localparam logic [6:0] ICC_ADR_L_LO = 7'h23;
    localparam logic [6:0] ICC_ADR_L_HI = 7'h24;
    localparam logic [6:0] ICC_ADR_RC_LO = 7'h30;
    localparam logic [6:0] ICC_ADR_RC_HI = 7'h31;
    localparam logic [6:0] ICC_ADR_HR0 = 7'h38;
    localparam logic [6:0] ICC_ADR_HR1 = 7'h39;
    localparam logic [6:0] ICC_ADR_HR2 = 7'h3A;
    localparam logic [6:0] ICC_ADR_HSTAT = 7'h3B;
    // Field positions.
    localparam int ICC_BIT_RDY = 6;
    localparam int ICC_BIT_HRDY = 0;
    localparam int ICC_BIT_MAXDIS = 7;
    localparam int ICC_POS_FREQ = 4;
    // Mode encodings and reset values.
    localparam logic [1:0] ICC_MODE_ACTIVE = 2'h0;
    localparam logic [1:0] ICC_MODE_SLEEP = 2'h1;
    localparam logic [7:0] ICC_RST_CFG = 8'h00;
    localparam logic [7:0] ICC_RST_MODE = 8'h01;
    localparam logic [15:0] ICC_RST_HIRES_REFERENCE_COUNT = 16'h0080;
    localparam logic [3:0] ICC_FREQ_4MHZ = 4'hE;
    // Timing: reference cycles per count and fixed post-processing time.
    localparam int ICC_CYC_PER_COUNT = 16;
    localparam int ICC_POST_CYC = 55;
    // Response time base in reference ticks; setting 6144 is six units of 1024.
    localparam int ICC_RESP_UNIT = 1024;
    localparam logic [2:0] ICC_RESP_MIN = 3'h2;
    // Resistance/inductance conversion: one tick per reference cycle; the RP/L timer does not apply this prescale.
    localparam int ICC_RPL_PRESCALE = 1;
    // SPI framing: command byte then data bytes.
    localparam int ICC_BYTE_BITS = 8;
    // Serial interface states.
    typedef enum logic [3:0] {
        ICC_SP_CMD = 4'h1,
        ICC_SP_WR = 4'h2,
        ICC_SP_RD = 4'h4,
        ICC_SP_IDLE = 4'h8
    } icc_sp_state_t;
endpackage
`default_nettype wire

// ==== hw/icc_sync.sv ====
// Two flip-flop synchroniser for the pin inputs.
`default_nettype none
module icc_sync
    import icc_pkg::*;
#(
    parameter int WIDTH = 4
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Asynchronous levels in, synchronised levels out.
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } icc_sync_st_t;
    icc_sync_st_t st;
    icc_sync_st_t next_st;

    // The first stage feeds only the second stage.
    always_comb begin
        next_st.meta = i_async;
        next_st.sync = st.meta;
    end

    // Reset to all ones so that an idle chip select reads inactive.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st <= '1;
        end else begin
            st <= next_st;
        end
    end

    assign o_sync = st.sync;
endmodule
`default_nettype wire

// ==== hw/icc_conv.sv ====
// Conversion timer: counts reference-clock edges and posts a result on each period end.
`default_nettype none
module icc_conv
    import icc_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Control.
    input wire logic i_run,
    input wire logic i_ref_tick,
    input wire logic [23:0] i_period,
    // Completion pulse.
    output logic o_done
);
    typedef struct packed {
        logic [23:0] cnt;
        logic done;
    } icc_conv_st_t;
    icc_conv_st_t st;
    icc_conv_st_t next_st;

    // Count reference ticks; a stopped timer restarts from zero.
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (!i_run) begin
            next_st.cnt = '0;
        end else if (i_ref_tick) begin
            if (st.cnt + 24'h1 >= i_period) begin
                next_st.cnt = '0;
                next_st.done = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 24'h1;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_done = st.done;
endmodule
`default_nettype wire

// ==== hw/icc_top.sv ====
// Inductive converter control: SPI register file, conversion sequencing and result readout.
`default_nettype none
module icc_top
    import icc_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // SPI slave pins.
    input wire logic i_spi_cs_n,
    input wire logic i_spi_sck,
    input wire logic i_spi_mosi,
    output logic o_spi_miso,
    output logic o_spi_miso_oe,
    // External reference clock pin.
    input wire logic i_ref_clk,
    // Raw results from the analog measurement cores.
    input wire logic [15:0] i_rp_code,
    input wire logic [15:0] i_l_code,
    input wire logic [23:0] i_hr_code,
    // Configuration outputs to the analog front end.
    output logic o_converting,
    output logic o_max_range_disable,
    output logic [2:0] o_max_resistance_code,
    output logic [2:0] o_min_resistance_code,
    output logic [1:0] o_first_cap_code,
    output logic [4:0] o_first_res_code,
    output logic [7:0] o_time_constant_two,
    output logic [3:0] o_watchdog_freq_field,
    output logic [2:0] o_response_time_field,
    output logic o_watchdog_4mhz
);
    typedef struct packed {
        icc_sp_state_t sp;
        logic [2:0] bitc;
        logic [7:0] shin;
        logic [7:0] shout;
        logic rd;
        logic [6:0] adr;
        logic sck_q;
        logic ref_q;
        logic [7:0] sensor_range_config;
        logic [7:0] time_constant_one;
        logic [7:0] time_constant_two;
        logic [7:0] digital_config;
        logic [7:0] conversion_mode_ctrl;
        logic [15:0] hires_reference_count;
        logic [15:0] rp_res;
        logic [15:0] l_res;
        logic [23:0] hr_res;
        logic result_ready_n;
        logic hires_ready_n;
        logic miso;
        logic miso_oe;
        logic wd4;
        logic converting;
        logic [23:0] rp_ticks;
        logic [23:0] hr_ticks;
    } icc_st_t;
    icc_st_t st;
    icc_st_t next_st;

    logic [3:0] pins;
    logic cs_n;
    logic sck;
    logic mosi;
    logic ref_s;
    logic ref_tick;
    logic run;
    logic rpl_done;
    logic hr_done;
    logic [23:0] rpl_period;
    logic [23:0] hr_period;

    // Pins cross from outside into this clock domain.
    icc_sync #(.WIDTH(4)) u_sync (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_async({i_spi_cs_n, i_spi_sck, i_spi_mosi, i_ref_clk}),
        .o_sync(pins)
    );
    assign cs_n = pins[3];
    assign sck = pins[2];
    assign mosi = pins[1];
    assign ref_s = pins[0];
    assign ref_tick = ref_s & ~st.ref_q;

    // Sleep is any mode other than active; reset leaves the block asleep.
    assign run = (st.conversion_mode_ctrl[1:0] == ICC_MODE_ACTIVE); // RQ1 RQ3

    // Response code sets the RP/L period in reference ticks: 7 is 6144 and each step down to 2 halves it; codes below 2 act as 2. RQ18
    function automatic logic [23:0] resp_len(input logic [2:0] code);
        logic [2:0] c;
        c = (code < ICC_RESP_MIN) ? ICC_RESP_MIN : code;
        case (c)
            3'h7: resp_len = 24'(6 * ICC_RESP_UNIT);
            3'h6: resp_len = 24'(3 * ICC_RESP_UNIT);
            3'h5: resp_len = 24'(3 * ICC_RESP_UNIT / 2);
            3'h4: resp_len = 24'(3 * ICC_RESP_UNIT / 4);
            3'h3: resp_len = 24'(3 * ICC_RESP_UNIT / 8);
            default: resp_len = 24'(3 * ICC_RESP_UNIT / 16);
        endcase
    endfunction
    assign rpl_period = resp_len(st.digital_config[2:0]); // RQ18

    // Reference ticks since the last completion; kept beside each timer so the period checks
    // measure the real spacing of results rather than restating the period expression.
    function automatic logic [23:0] tick_cnt(input logic [23:0] cnt, input logic go, input logic done,
        input logic tick);
        if (!go) begin
            tick_cnt = 24'h0;
        end else if (done) begin
            tick_cnt = {23'h0, tick};
        end else begin
            tick_cnt = cnt + {23'h0, tick};
        end
    endfunction

    // High-resolution period: 16 cycles per count plus 55 post cycles.
    assign hr_period = 24'({st.hires_reference_count, 4'h0}) + 24'(ICC_POST_CYC); // RQ11 RQ10

    // Two independent timers, so completions never share a ready flag.
    icc_conv u_rpl (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_run(run),
        .i_ref_tick(ref_tick),
        .i_period(rpl_period),
        .o_done(rpl_done)
    ); // RQ12
    icc_conv u_hr (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_run(run),
        .i_ref_tick(ref_tick),
        .i_period(hr_period),
        .o_done(hr_done)
    ); // RQ12

    // Register read decode shared by the shift logic.
    function automatic logic [7:0] rd_reg(input icc_st_t s, input logic [6:0] a);
        case (a)
            ICC_ADR_RANGE: rd_reg = s.sensor_range_config;
            ICC_ADR_TC1: rd_reg = s.time_constant_one;
            ICC_ADR_TC2: rd_reg = s.time_constant_two;
            ICC_ADR_DIG: rd_reg = s.digital_config;
            ICC_ADR_MODE: rd_reg = s.conversion_mode_ctrl;
            ICC_ADR_STAT: rd_reg = 8'(s.result_ready_n) << ICC_BIT_RDY; // RQ4
            ICC_ADR_RP_LO: rd_reg = s.rp_res[7:0]; // RQ5
            ICC_ADR_RP_HI: rd_reg = s.rp_res[15:8]; // RQ5
            ICC_ADR_L_LO: rd_reg = s.l_res[7:0]; // RQ6
            ICC_ADR_L_HI: rd_reg = s.l_res[15:8]; // RQ6
            ICC_ADR_RC_LO: rd_reg = s.hires_reference_count[7:0]; // RQ10
            ICC_ADR_RC_HI: rd_reg = s.hires_reference_count[15:8]; // RQ10
            ICC_ADR_HR0: rd_reg = s.hr_res[7:0]; // RQ9 RQ19
            ICC_ADR_HR1: rd_reg = s.hr_res[15:8]; // RQ9 RQ19
            ICC_ADR_HR2: rd_reg = s.hr_res[23:16]; // RQ9 RQ19
            ICC_ADR_HSTAT: rd_reg = 8'(s.hires_ready_n) << ICC_BIT_HRDY; // RQ8
            default: rd_reg = 8'h00;
        endcase
    endfunction

    logic sck_rise;
    logic sck_fall;
    assign sck_rise = sck & ~st.sck_q;
    assign sck_fall = ~sck & st.sck_q;

    // SPI mode 0: sample on rising SCK, shift out on falling SCK.
    always_comb begin
        logic [7:0] byte_in;
        logic [7:0] rdat;
        byte_in = {st.shin[6:0], mosi};
        rdat = 8'h00;
        next_st = st;
        next_st.sck_q = sck;
        next_st.ref_q = ref_s;
        next_st.wd4 = (st.digital_config[7:ICC_POS_FREQ] == ICC_FREQ_4MHZ); // RQ16
        // Tick counters follow the timers; a stopped timer starts them over.
        next_st.rp_ticks = tick_cnt(st.rp_ticks, run, rpl_done, ref_tick); // RQ18
        next_st.hr_ticks = tick_cnt(st.hr_ticks, run, hr_done, ref_tick); // RQ11
        // Results are captured at completion; a new result sets the flag low.
        if (rpl_done) begin
            next_st.rp_res = i_rp_code;
            next_st.l_res = i_l_code;
        end
        if (hr_done) begin
            next_st.hr_res = i_hr_code;
        end
        if (cs_n) begin
            next_st.sp = ICC_SP_IDLE;
            next_st.miso_oe = 1'b0;
            next_st.miso = 1'b0;
        end else begin
            next_st.miso_oe = st.rd && (st.sp == ICC_SP_RD);
            case (st.sp)
                ICC_SP_IDLE: begin
                    next_st.sp = ICC_SP_CMD;
                    next_st.bitc = 3'h0;
                end
                ICC_SP_CMD: begin
                    if (sck_rise) begin
                        next_st.shin = byte_in;
                        next_st.bitc = st.bitc + 3'h1;
                        if (st.bitc == 3'h7) begin
                            next_st.rd = byte_in[7];
                            next_st.adr = byte_in[6:0];
                            next_st.sp = byte_in[7] ? ICC_SP_RD : ICC_SP_WR;
                            next_st.shout = rd_reg(st, byte_in[6:0]);
                        end
                    end
                end
                ICC_SP_WR: begin
                    if (sck_rise) begin
                        next_st.shin = byte_in;
                        next_st.bitc = st.bitc + 3'h1;
                        if (st.bitc == 3'h7) begin
                            case (st.adr)
                                ICC_ADR_RANGE: next_st.sensor_range_config = byte_in; // RQ13
                                ICC_ADR_TC1: next_st.time_constant_one = byte_in; // RQ14
                                ICC_ADR_TC2: next_st.time_constant_two = byte_in;
                                ICC_ADR_DIG: next_st.digital_config = byte_in; // RQ15
                                ICC_ADR_MODE: next_st.conversion_mode_ctrl = byte_in; // RQ2 RQ3
                                ICC_ADR_RC_LO: next_st.hires_reference_count[7:0] = byte_in; // RQ10
                                ICC_ADR_RC_HI: next_st.hires_reference_count[15:8] = byte_in; // RQ10
                                default: ;
                            endcase
                            next_st.adr = st.adr + 7'h1; // RQ7
                        end
                    end
                end
                ICC_SP_RD: begin
                    if (sck_fall && st.bitc != 3'h0) begin
                        next_st.shout = {st.shout[6:0], 1'b0};
                    end
                    if (sck_rise) begin
                        next_st.bitc = st.bitc + 3'h1;
                        if (st.bitc == 3'h7) begin
                            // Reading a result byte consumes its ready flag. RQ20
                            if (st.adr >= ICC_ADR_RP_LO && st.adr <= ICC_ADR_L_HI) begin
                                next_st.result_ready_n = 1'b1;
                            end
                            if (st.adr >= ICC_ADR_HR0 && st.adr <= ICC_ADR_HR2) begin
                                next_st.hires_ready_n = 1'b1;
                            end
                            rdat = rd_reg(st, st.adr + 7'h1);
                            next_st.adr = st.adr + 7'h1; // RQ7
                            next_st.shout = rdat;
                        end
                    end
                    next_st.miso = next_st.shout[7];
                end
                default: next_st.sp = ICC_SP_IDLE;
            endcase
        end
        // A new result wins over a read clear in the same cycle. RQ20
        if (rpl_done) begin
            next_st.result_ready_n = 1'b0; // RQ4
        end
        if (hr_done) begin
            next_st.hires_ready_n = 1'b0; // RQ8
        end
        // Registered copy of the run decode, so the pin matches the timers cycle for cycle.
        next_st.converting = (next_st.conversion_mode_ctrl[1:0] == ICC_MODE_ACTIVE); // RQ1 RQ3
    end

    // Reset puts the mode register in sleep and both flags to not ready.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st <= '0;
            st.sp <= ICC_SP_IDLE;
            // Edge detectors start at the synchroniser's reset level, so no false rising edge follows reset.
            st.sck_q <= 1'b1;
            st.ref_q <= 1'b1;
            st.sensor_range_config <= ICC_RST_CFG;
            st.time_constant_one <= ICC_RST_CFG;
            st.time_constant_two <= ICC_RST_CFG;
            st.digital_config <= ICC_RST_CFG;
            st.conversion_mode_ctrl <= ICC_RST_MODE; // RQ1
            st.hires_reference_count <= ICC_RST_HIRES_REFERENCE_COUNT;
            st.result_ready_n <= 1'b1;
            st.hires_ready_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs come straight from state flip-flops.
    assign o_spi_miso = st.miso;
    assign o_spi_miso_oe = st.miso_oe;
    assign o_converting = st.converting;
    assign o_max_range_disable = st.sensor_range_config[ICC_BIT_MAXDIS]; // RQ13 RQ17
    assign o_max_resistance_code = st.sensor_range_config[6:4]; // RQ13
    assign o_min_resistance_code = st.sensor_range_config[2:0]; // RQ13
    assign o_first_cap_code = st.time_constant_one[7:6]; // RQ14
    assign o_first_res_code = st.time_constant_one[4:0]; // RQ14
    assign o_time_constant_two = st.time_constant_two;
    assign o_watchdog_freq_field = st.digital_config[7:4]; // RQ15
    assign o_response_time_field = st.digital_config[2:0]; // RQ15
    assign o_watchdog_4mhz = st.wd4; // RQ16

    // Sleep: once a full cycle has passed asleep, a completion launched just before the stop is over.
    chk_sleep_no_done: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ1
        !run && !$past(run) |-> !rpl_done && !hr_done) else $error("Result while asleep.");
    chk_rpl_flag_set: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ4
        rpl_done |=> !st.result_ready_n) else $error("Ready flag not set.");
    chk_hr_flag_set: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ8
        hr_done |=> !st.hires_ready_n && st.hr_res == $past(i_hr_code)) else $error("HR result not posted.");
    chk_rp_capture: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ5
        rpl_done |=> st.rp_res == $past(i_rp_code) && st.l_res == $past(i_l_code)) else $error("RP/L capture.");
    // Periods are measured in ticks between completions; count writes only happen asleep.
    chk_hr_period: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ11
        hr_done |-> st.hr_ticks == 24'(ICC_CYC_PER_COUNT) * 24'(st.hires_reference_count) + 24'(ICC_POST_CYC))
        else $error("HR period wrong.");
    chk_rpl_period: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ18
        rpl_done && st.digital_config[2:1] == 2'h3 |-> st.rp_ticks == (st.digital_config[0] ? 24'h1800 : 24'hC00))
        else $error("RP/L period wrong.");
    chk_stop_mode: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ2
        st.conversion_mode_ctrl == 8'h01 |-> !run) else $error("Not stopped.");
    chk_miso_idle: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ7
        $rose(cs_n) |=> !o_spi_miso_oe) else $error("MISO driven after deselect.");
    chk_oe_read: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ7
        st.sp == ICC_SP_RD && !cs_n |=> o_spi_miso_oe) else $error("MISO not driven during read.");
    chk_wd_code: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ16
        st.digital_config[7:4] == 4'hE |=> o_watchdog_4mhz) else $error("Watchdog 4 MHz missing.");
endmodule
`default_nettype wire

// ==== test/icc_host.sv ====
// Host microcontroller model: SPI mode 0 master that frames register accesses.
`default_nettype none
module icc_host (
    // Clock.
    input wire logic i_clk,
    // SPI pins towards the device.
    output logic o_cs_n,
    output logic o_sck,
    output logic o_mosi,
    input wire logic i_miso
);
    timeunit 1ns;
    timeprecision 1ps;
    // Half SCK period in system cycles; the device needs at least four.
    localparam int HALF = 6;

    // Pins idle with the device deselected.
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_mosi = 1'b0;
    end

    // One byte MSB first; MOSI moves while SCK is low, MISO is taken as SCK rises.
    task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
        for (int b = 7; b >= 0; b--) begin
            @(posedge i_clk);
            o_mosi <= tx[b];
            repeat (HALF) @(posedge i_clk);
            rx[b] = i_miso;
            o_sck <= 1'b1;
            repeat (HALF) @(posedge i_clk);
            o_sck <= 1'b0;
        end
    endtask

    // Command byte then n data bytes with the address advancing in one frame.
    task automatic frame(input logic [7:0] cmd, input int n, input logic [7:0] wq[$], output logic [7:0] rq[$]);
        logic [7:0] rx;
        rq = {};
        @(posedge i_clk);
        o_cs_n <= 1'b0;
        shift(cmd, rx);
        for (int i = 0; i < n; i++) begin
            shift((i < wq.size()) ? wq[i] : 8'h00, rx);
            rq.push_back(rx);
        end
        repeat (HALF) @(posedge i_clk);
        o_cs_n <= 1'b1;
        // A released data line must not look like a held value.
        o_mosi <= ~o_mosi;
        repeat (HALF) @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

// ==== test/tb_inductive_converter_control.sv ====
// Self-checking bench for the inductive converter control block.
`default_nettype none
module tb_inductive_converter_control
    import icc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic cs_n, sck, mosi, miso, miso_oe, conv, maxdis, w4;
    logic [2:0] rdiv = 3'h0;
    logic [15:0] rp_code, l_code;
    logic [23:0] hr_code;
    logic [2:0] maxc, minc, resp;
    logic [1:0] c1;
    logic [4:0] r1;
    logic [7:0] tc2;
    logic [3:0] wf;
    logic [31:0] seed = 32'h65AD5CAB;
    logic [31:0] r;
    logic [7:0] mdl [0:127];
    logic [7:0] rq[$];
    logic [7:0] nil[$];
    int n_fail = 0;
    int num_checks = 0;

    icc_host icc_host_i (.i_clk(i_clk), .o_cs_n(cs_n), .o_sck(sck), .o_mosi(mosi), .i_miso(miso));
    icc_top icc_top_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_spi_cs_n(cs_n), .i_spi_sck(sck),
        .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(miso_oe), .i_ref_clk(rdiv[2]),
        .i_rp_code(rp_code), .i_l_code(l_code), .i_hr_code(hr_code), .o_converting(conv),
        .o_max_range_disable(maxdis), .o_max_resistance_code(maxc), .o_min_resistance_code(minc),
        .o_first_cap_code(c1), .o_first_res_code(r1), .o_time_constant_two(tc2),
        .o_watchdog_freq_field(wf), .o_response_time_field(resp), .o_watchdog_4mhz(w4));

    // System clock, 8 ns period.
    initial begin
        forever #4 i_clk = ~i_clk;
    end

    // Reference clock at one eighth of the system clock, well under the quarter limit.
    always @(posedge i_clk) begin
        rdiv <= rdiv + 3'h1;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic bit is_rw(input logic [6:0] a);
        return a inside {ICC_ADR_RANGE, ICC_ADR_TC1, ICC_ADR_TC2, ICC_ADR_DIG, ICC_ADR_MODE, ICC_ADR_RC_LO,
            ICC_ADR_RC_HI};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Writes land in the model only where the register is writable.
    task automatic wr(input logic [6:0] a, input logic [7:0] d[$]);
        icc_host_i.frame({1'b0, a}, d.size(), d, rq);
        foreach (d[i]) if (is_rw(7'(a + i))) mdl[7'(a + i)] = d[i];
    endtask

    task automatic rd(input logic [6:0] a, input int n);
        icc_host_i.frame({1'b1, a}, n, nil, rq);
    endtask

    task automatic rdchk(input logic [6:0] a, input int n);
        rd(a, n);
        foreach (rq[i]) chk(rq[i], mdl[7'(a + i)]);
    endtask

    // Polls an active-low ready bit under a bounded count.
    task automatic poll(input logic [6:0] a, input int b);
        int k;
        k = 0;
        do begin
            rd(a, 1);
            k++;
        end while (rq[0][b] !== 1'b0 && k < 200);
        chk(rq[0][b], 1'b0);
    endtask

    task automatic test_done();
        $display("checks=%0d failures=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Main sequence: reset state, configuration, both conversions, stop.
    initial begin
        r = rnd();
        rp_code = r[15:0];
        l_code = r[31:16];
        hr_code = 24'h000000;
        foreach (mdl[i]) mdl[i] = 8'h00;
        mdl[ICC_ADR_MODE] = ICC_RST_MODE;
        mdl[ICC_ADR_RC_LO] = ICC_RST_HIRES_REFERENCE_COUNT[7:0];
        repeat (4) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk({conv, miso_oe, w4}, 3'b000);
        rdchk(ICC_ADR_RANGE, 4);
        rdchk(ICC_ADR_MODE, 1);
        rdchk(ICC_ADR_RC_LO, 2);
        rd(ICC_ADR_STAT, 1);
        chk(rq[0][ICC_BIT_RDY], 1'b1);
        // Disable bit stays clear because the sensor quality is below fifty.
        r = rnd();
        wr(ICC_ADR_RANGE, '{8'h36, 8'hDE, r[7:0], 8'hE6});
        chk({maxdis, maxc, minc}, {1'b0, 3'b011, 3'b110});
        chk({c1, r1}, {2'b11, 5'b11110});
        chk(tc2, r[7:0]);
        chk({wf, resp, w4}, {4'hE, 3'h6, 1'b1});
        rdchk(ICC_ADR_RANGE, 4);
        wr(7'h05, '{8'hA5});
        rdchk(7'h05, 1);
        wr(ICC_ADR_RC_LO, '{8'h4A, 8'h01});
        rdchk(ICC_ADR_RC_LO, 2);
        // Short count keeps the run brief: 16*8+55 ticks per result.
        wr(ICC_ADR_RC_LO, '{8'h08, 8'h00});
        r = rnd();
        rp_code <= r[15:0];
        l_code <= r[31:16];
        {mdl[ICC_ADR_RP_HI], mdl[ICC_ADR_RP_LO]} = r[15:0];
        {mdl[ICC_ADR_L_HI], mdl[ICC_ADR_L_LO]} = r[31:16];
        r = rnd();
        hr_code <= r[23:0];
        {mdl[ICC_ADR_HR2], mdl[ICC_ADR_HR1], mdl[ICC_ADR_HR0]} = r[23:0];
        wr(ICC_ADR_MODE, '{8'h00});
        repeat (4) @(posedge i_clk);
        chk(conv, 1'b1);
        poll(ICC_ADR_HSTAT, ICC_BIT_HRDY);
        rdchk(ICC_ADR_HR0, 3);
        rd(ICC_ADR_HSTAT, 1);
        chk(rq[0][ICC_BIT_HRDY], 1'b1);
        poll(ICC_ADR_STAT, ICC_BIT_RDY);
        rdchk(ICC_ADR_RP_LO, 4);
        rd(ICC_ADR_STAT, 1);
        chk(rq[0][ICC_BIT_RDY], 1'b1);
        wr(ICC_ADR_RP_LO, '{~mdl[ICC_ADR_RP_LO]});
        rdchk(ICC_ADR_RP_LO, 1);
        wr(ICC_ADR_MODE, '{8'h01});
        repeat (4) @(posedge i_clk);
        chk(conv, 1'b0);
        rdchk(ICC_ADR_MODE, 1);
        // Results posted while active are consumed now, so only a result made asleep could set a flag.
        rdchk(ICC_ADR_HR0, 3);
        rdchk(ICC_ADR_RP_LO, 4);
        repeat (2000) @(posedge i_clk);
        rd(ICC_ADR_STAT, 1);
        chk(rq[0][ICC_BIT_RDY], 1'b1);
        rd(ICC_ADR_HSTAT, 1);
        chk(rq[0][ICC_BIT_HRDY], 1'b1);
        test_done();
    end

    // Watchdog sized well past the expected run of about thirty-three thousand cycles.
    initial begin
        #700us;
        n_fail++;
        test_done();
    end
endmodule
`default_nettype wire
